// ===== logic/upm_ctrl.sv
// Power-down, start-up and interface mode control of the link-side port
`timescale 1ns/1ps
`default_nettype none
module upm_ctrl
	import upm_pkg::*;
#(
	parameter int unsigned STABLE_CYC = CLK_STABLE_CYC
)
(
	// Clock and reset
	input  wire logic          CORE_CLK_I,
	input  wire logic          RST_I,
	// Chip select and reference
	input  wire logic          CHIP_SEL_I,
	input  wire logic          CHIP_SEL_N_I,
	input  wire logic          OSC_PRESENT_I,
	// Link pins
	input  wire logic [7:0]    DATA_I,
	output logic      [7:0]    DATA_O,
	output logic      [7:0]    DATA_OE_O,
	output logic               DIR_O,
	output logic               DIR_OE_O,
	output logic               NXT_O,
	output logic               NXT_OE_O,
	input  wire logic          STP_I,
	// Core side
	input  wire upm_mode_req_s MODE_REQ_I,
	input  wire upm_rx_s       RX_I,
	input  wire logic          TX_READY_I,
	input  wire logic [7:0]    ALT_DATA_I,
	output upm_tx_s            TX_O,
	output logic               RX_TAKE_O,
	output upm_mode_e          MODE_O,
	// Power and clock control
	output logic               REG_EN_O,
	output logic               CLK_RUN_O
);

	upm_pwr_e          pstate;
	upm_pwr_e          next_pstate;
	logic [CNT_W-1:0]  cnt;
	logic [CNT_W-1:0]  next_cnt;
	upm_mode_e         mode;
	upm_mode_e         next_mode;
	logic              dir;
	logic              next_dir;
	logic              dir_last;
	logic              tx_busy;
	logic              next_tx_busy;
	logic              nxt;
	logic              next_nxt;
	logic [7:0]        data_out;
	logic [7:0]        next_data_out;
	logic [7:0]        data_oe;
	logic [7:0]        next_data_oe;
	logic              pin_oe;
	logic              next_pin_oe;
	logic              reg_en;
	logic              next_reg_en;
	logic              clk_run;
	logic              next_clk_run;
	upm_tx_s           tx;
	upm_tx_s           next_tx;
	logic              rx_take;
	logic              next_rx_take;
	logic              cs_on;
	logic              turn;
	logic [7:0]        mask;

	always_comb
	begin
		cs_on         = CHIP_SEL_I & ~CHIP_SEL_N_I;
		turn          = dir_last != dir;
		next_pstate   = pstate;
		next_cnt      = cnt;
		next_mode     = mode;
		next_dir      = dir;
		next_tx_busy  = tx_busy;
		next_nxt      = 1'b0;
		next_tx       = '0;
		next_rx_take  = 1'b0;
		next_data_out = DATA_IDLE;
		next_data_oe  = '0;
		next_pin_oe   = 1'b0;
		next_reg_en   = 1'b0;
		next_clk_run  = 1'b0;
		mask          = MASK_SYNC;
		if (!cs_on)
		begin
			// Everything released; stop is ignored
			next_pstate  = PW_DOWN;
			next_cnt     = '0;
			next_mode    = MODE_SYNC;
			next_dir     = 1'b0;
			next_tx_busy = 1'b0;
		end
		else
		begin
			next_reg_en = 1'b1;
			next_pin_oe = 1'b1;
			unique case (pstate)
				PW_DOWN:
				begin
					// Direction held high to keep the link off the bus
					next_pstate = PW_START;
					next_cnt    = '0;
					next_dir    = 1'b1;
				end
				PW_START:
				begin
					next_dir = 1'b1;
					if (OSC_PRESENT_I)
					begin
						if (cnt >= CNT_W'(STABLE_CYC - 1))
						begin
							next_pstate = PW_ON;
							next_mode   = MODE_SYNC;
							next_dir    = 1'b0;
						end
						else
						begin
							next_cnt = cnt + CNT_W'(1);
						end
					end
				end
				PW_ON:
				begin
					if (mode != MODE_SYNC)
					begin
						// Wake-up by stop returns to synchronous
						next_dir = 1'b1;
						if (STP_I)
						begin
							next_mode = MODE_SYNC;
							next_dir  = 1'b0;
						end
					end
					else if (MODE_REQ_I.valid && $onehot(MODE_REQ_I.mode)
						&& MODE_REQ_I.mode != MODE_SYNC && !tx_busy)
					begin
						next_mode = MODE_REQ_I.mode;
						next_dir  = 1'b1;
					end
					else if (dir)
					begin
						if (STP_I || !RX_I.valid)
						begin
							next_dir = 1'b0;
						end
					end
					else if (!turn)
					begin
						if (tx_busy)
						begin
							if (STP_I)
							begin
								next_tx.stop = 1'b1;
								next_tx_busy = 1'b0;
							end
							else
							begin
								next_nxt = TX_READY_I;
								if (nxt)
								begin
									next_tx.dat  = 1'b1;
									next_tx.data = DATA_I;
								end
							end
						end
						else if (DATA_I != DATA_IDLE)
						begin
							next_tx.cmd  = 1'b1;
							next_tx.data = DATA_I;
							next_tx_busy = 1'b1;
							next_nxt     = TX_READY_I;
						end
						else if (RX_I.valid)
						begin
							next_dir = 1'b1;
						end
					end
				end
				default:
				begin
					next_pstate = PW_DOWN;
				end
			endcase
			// Clock kept only in synchronous mode to save power elsewhere
			next_clk_run = OSC_PRESENT_I && next_mode == MODE_SYNC;
			mask = upm_mode_mask(next_mode);
			// Data enables stay off in the cycle direction rises and during start-up
			if (next_dir && dir && pstate == PW_ON)
			begin
				next_data_oe = mask;
				if (next_mode == MODE_SYNC)
				begin
					if (RX_I.valid && next_data_oe != '0)
					begin
						next_data_out = RX_I.data;
						next_nxt      = RX_I.usb;
						next_rx_take  = 1'b1;
					end
				end
				else
				begin
					next_data_out = ALT_DATA_I & mask;
				end
			end
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			pstate   <= PW_DOWN;
			cnt      <= '0;
			mode     <= MODE_SYNC;
			dir      <= 1'b0;
			dir_last <= 1'b0;
			tx_busy  <= 1'b0;
			nxt      <= 1'b0;
			data_out <= DATA_IDLE;
			data_oe  <= '0;
			pin_oe   <= 1'b0;
			reg_en   <= 1'b0;
			clk_run  <= 1'b0;
			tx       <= '0;
			rx_take  <= 1'b0;
		end
		else
		begin
			pstate   <= next_pstate;
			cnt      <= next_cnt;
			mode     <= next_mode;
			dir      <= next_dir;
			dir_last <= dir;
			tx_busy  <= next_tx_busy;
			nxt      <= next_nxt;
			data_out <= next_data_out;
			data_oe  <= next_data_oe;
			pin_oe   <= next_pin_oe;
			reg_en   <= next_reg_en;
			clk_run  <= next_clk_run;
			tx       <= next_tx;
			rx_take  <= next_rx_take;
		end
	end

	assign DATA_O    = data_out;
	assign DATA_OE_O = data_oe;
	assign DIR_O     = dir;
	assign DIR_OE_O  = pin_oe;
	assign NXT_O     = nxt;
	assign NXT_OE_O  = pin_oe;
	assign TX_O      = tx;
	assign RX_TAKE_O = rx_take;
	assign MODE_O    = mode;
	assign REG_EN_O  = reg_en;
	assign CLK_RUN_O = clk_run;

endmodule
`default_nettype wire

// ===== logic/upm_pkg.sv
// Constants, types and mode table for the interface power and mode control
package upm_pkg;

	typedef enum logic [4:0]
	{
		MODE_SYNC = 5'b0_0001,
		MODE_LPM  = 5'b0_0010,
		MODE_SER6 = 5'b0_0100,
		MODE_SER3 = 5'b0_1000,
		MODE_UART = 5'b1_0000
	} upm_mode_e;

	typedef enum logic [2:0]
	{
		PW_DOWN  = 3'b001,
		PW_START = 3'b010,
		PW_ON    = 3'b100
	} upm_pwr_e;

	typedef struct packed
	{
		logic       valid;
		upm_mode_e  mode;
	} upm_mode_req_s;

	typedef struct packed
	{
		logic       valid;
		logic       usb;
		logic [7:0] data;
	} upm_rx_s;

	typedef struct packed
	{
		logic       cmd;
		logic       dat;
		logic       stop;
		logic [7:0] data;
	} upm_tx_s;

	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned CLK_STABLE_NS   = 1000;
	localparam int unsigned CLK_STABLE_CYC  = (CLK_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W           = 16;

	localparam logic [7:0] MASK_SYNC = 8'hFF;
	localparam logic [7:0] MASK_LPM  = 8'h0B;
	localparam logic [7:0] MASK_SER6 = 8'h78;
	localparam logic [7:0] MASK_SER3 = 8'h08;
	localparam logic [7:0] MASK_UART = 8'h0A;
	localparam logic [7:0] DATA_IDLE = 8'h00;

	function automatic logic [7:0] upm_mode_mask(input upm_mode_e m);
		logic [7:0] r;
		r = MASK_SYNC;
		unique case (m)
			MODE_SYNC: r = MASK_SYNC;
			MODE_LPM:  r = MASK_LPM;
			MODE_SER6: r = MASK_SER6;
			MODE_SER3: r = MASK_SER3;
			MODE_UART: r = MASK_UART;
			default:   r = MASK_SYNC;
		endcase
		return r;
	endfunction

endpackage

// ===== dv/upm_ctrl_sva.sv
// Port checker for power and mode control
`timescale 1ns/1ps
`default_nettype none
module upm_chk
	import upm_pkg::*;
(
	// Clock and reset
	input	wire logic		CORE_CLK_I,
	input	wire logic		RST_I,
	// Watched ports
	input	wire logic		CHIP_SEL_I,
	input	wire logic		CHIP_SEL_N_I,
	input	wire logic		OSC_PRESENT_I,
	input	wire logic [7:0]	DATA_I,
	input	wire logic [7:0]	DATA_OE_O,
	input	wire logic		DIR_O,
	input	wire logic		DIR_OE_O,
	input	wire logic		NXT_OE_O,
	input	wire upm_tx_s		TX_O,
	input	wire upm_mode_e		MODE_O,
	input	wire logic		REG_EN_O,
	input	wire logic		CLK_RUN_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	wire logic cs = CHIP_SEL_I && !CHIP_SEL_N_I;
	a_off_release: assert property (!cs |=> !DIR_OE_O && !NXT_OE_O && DATA_OE_O == 8'h00)
		else $error("pins driven while deselected");
	a_off_down: assert property (!cs |=> !REG_EN_O && MODE_O == MODE_SYNC)
		else $error("not powered down");
	a_one_mode: assert property ($onehot(MODE_O))
		else $error("mode not one-hot");
	a_turn_cycle: assert property ($changed(DIR_O) |-> DATA_OE_O == 8'h00)
		else $error("bus driven in turnaround");
	a_nonsync_dir: assert property (MODE_O != MODE_SYNC |-> DIR_O)
		else $error("direction low outside sync");
	a_clk_gate: assert property (CLK_RUN_O |-> MODE_O == MODE_SYNC && $past(OSC_PRESENT_I))
		else $error("clock runs wrongly");
	a_txcmd_nz: assert property (TX_O.cmd |-> $past(DATA_I) != 8'h00)
		else $error("zero command taken");
	a_start_block: assert property ($rose(REG_EN_O) |-> DIR_O)
		else $error("link not blocked at start");
	cover property (TX_O.stop);
	cover property (MODE_O == MODE_UART);
	cover property ($fell(DIR_O));
endmodule
bind upm_ctrl upm_chk upm_chk_i (.CORE_CLK_I, .RST_I, .CHIP_SEL_I, .CHIP_SEL_N_I,
	.OSC_PRESENT_I, .DATA_I, .DATA_OE_O, .DIR_O, .DIR_OE_O, .NXT_OE_O, .TX_O,
	.MODE_O, .REG_EN_O, .CLK_RUN_O);
`default_nettype wire

// ===== dv/upm_link_model.sv
// Link-side model for the data bus and stop line
`timescale 1ns/1ps
`default_nettype none
module upm_link
(
	input	wire logic		clk,
	input	wire logic		go,
	input	wire logic		wake,
	input	wire logic [7:0]	cmd,
	input	wire logic [7:0]	dat,
	input	wire logic		dir,
	input	wire logic		nxt,
	input	wire logic [7:0]	dout,
	input	wire logic [7:0]	oe,
	output	logic [7:0]		data,
	output	logic			stp
);
	logic [1:0] st = 2'd0;
	logic [7:0] drv;
	// Released lines sit on pull-downs, never floating
	assign data = dir ? (dout & oe) : drv;
	assign drv = st == 2'd1 ? cmd : st == 2'd2 ? dat : 8'h00;
	assign stp = wake || st == 2'd3;
	// Launch half a period after the rising edge, sampled at the next one
	always @(negedge clk)
	begin
		case (st)
			2'd0: st <= go ? 2'd1 : 2'd0;
			2'd1: st <= nxt ? 2'd2 : 2'd1;
			2'd2: st <= nxt ? 2'd3 : 2'd2;
			default: st <= 2'd0;
		endcase
	end
endmodule
`default_nettype wire

// ===== dv/upm_ctrl_tb.sv
// Self-checking bench for power and mode control
`timescale 1ns/1ps
`default_nettype none
module upm_ctrl_tb;
	import upm_pkg::*;
	logic clk = 0, rst = 1, cs = 1, cs_n = 0, osc = 1, go = 0, wake = 0, stp;
	logic [7:0] din, dout, oe;
	logic dir, nxt, take, reg_en, clk_run, dir_oe, nxt_oe;
	upm_mode_req_s req = '0;
	upm_rx_s rx = '0;
	upm_tx_s tx;
	upm_mode_e mode;
	int err_total = 0, num_checks = 0, cyc = 0;
	always #20 clk = ~clk;
	upm_ctrl #(.STABLE_CYC(2)) upm_ctrl_i (.CORE_CLK_I(clk), .RST_I(rst), .CHIP_SEL_I(cs),
		.CHIP_SEL_N_I(cs_n), .OSC_PRESENT_I(osc), .DATA_I(din), .DATA_O(dout),
		.DATA_OE_O(oe), .DIR_O(dir), .DIR_OE_O(dir_oe), .NXT_O(nxt), .NXT_OE_O(nxt_oe),
		.STP_I(stp),
		.MODE_REQ_I(req), .RX_I(rx), .TX_READY_I(1'b1), .ALT_DATA_I(8'h5C), .TX_O(tx),
		.RX_TAKE_O(take), .MODE_O(mode), .REG_EN_O(reg_en), .CLK_RUN_O(clk_run));
	upm_link upm_link_i (.clk(clk), .go(go), .wake(wake), .cmd(8'hC1), .dat(8'h3A),
		.dir(dir), .nxt(nxt), .dout(dout), .oe(oe), .data(din), .stp(stp));
	task automatic print_verdict;
		if (err_total == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_total++;
			print_verdict();
		end
	end
	task automatic t_start;
		int n;
		n = 0;
		repeat (10) @(negedge clk);
		rst <= 0;
		@(negedge clk);
		chk("dir_start", 1, dir);
		while (dir && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		chk("mode", MODE_SYNC, mode);
		chk("reg_en", 1, reg_en);
		chk("dir_oe", 1, dir_oe);
		chk("clk_run", 1, clk_run);
		repeat (2) @(negedge clk);
	endtask
	task automatic t_tx;
		logic [7:0] c, d;
		logic s;
		c = 8'h00;
		d = 8'h00;
		s = 0;
		go <= 1;
		@(negedge clk);
		go <= 0;
		repeat (6)
		begin
			@(negedge clk);
			if (tx.cmd) c = tx.data;
			if (tx.dat) d = tx.data;
			if (tx.stop) s = 1;
		end
		chk("txcmd", 8'hC1, c);
		chk("txdat", 8'h3A, d);
		chk("txstop", 1, s);
	endtask
	task automatic t_rx;
		rx <= '{1'b1, 1'b1, 8'hA5};
		@(negedge clk);
		chk("rx_dir", 1, dir);
		chk("rx_turn", 8'h00, oe);
		@(negedge clk);
		rx <= '0;
		chk("rx_oe", 8'hFF, oe);
		chk("rx_data", 8'hA5, dout);
		chk("rx_nxt", 1, nxt);
		chk("rx_take", 1, take);
		@(negedge clk);
		chk("rx_end", 0, dir);
		repeat (2) @(negedge clk);
	endtask
	task automatic t_mode(input upm_mode_e m, input logic [7:0] k);
		req <= '{1'b1, m};
		@(negedge clk);
		req <= '0;
		chk("mode", m, mode);
		chk("clk_stop", 0, clk_run);
		@(negedge clk);
		chk("mode_oe", k, oe);
		chk("mode_out", 8'h5C & k, dout);
		wake <= 1;
		@(negedge clk);
		wake <= 0;
		chk("wake", MODE_SYNC, mode);
		repeat (2) @(negedge clk);
	endtask
	task automatic t_bad;
		req <= '{1'b1, upm_mode_e'(5'h03)};
		@(negedge clk);
		req <= '0;
		@(negedge clk);
		chk("bad_req", MODE_SYNC, mode);
	endtask
	task automatic t_off;
		cs_n <= 1;
		repeat (2) @(negedge clk);
		chk("off_oe", 8'h00, oe);
		chk("off_reg", 0, reg_en);
		chk("off_mode", MODE_SYNC, mode);
		chk("off_dir_oe", 0, dir_oe);
		chk("off_nxt_oe", 0, nxt_oe);
		osc <= 0;
		cs_n <= 0;
		repeat (4) @(negedge clk);
		chk("osc_wait", 1, dir);
		chk("osc_clk", 0, clk_run);
		osc <= 1;
		repeat (4) @(negedge clk);
		chk("restart", 0, dir);
		cs <= 0;
		repeat (2) @(negedge clk);
		chk("off_sel", 0, reg_en);
		chk("off_sel_oe", 0, nxt_oe);
	endtask
	initial
	begin
		t_start();
		t_tx();
		t_rx();
		t_mode(MODE_LPM, MASK_LPM);
		t_mode(MODE_SER6, MASK_SER6);
		t_mode(MODE_SER3, MASK_SER3);
		t_mode(MODE_UART, MASK_UART);
		t_bad();
		t_off();
		print_verdict();
	end
endmodule
`default_nettype wire
